// >>> src/sltc_pkg.sv
// constants and carrier types of the switch link test controller
package sltc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_SIG     = 8'h08;
    localparam logic [7:0] OFF_PKT     = 8'h0c;
    localparam logic [7:0] OFF_LT_ERR  = 8'h10;
    localparam logic [7:0] OFF_TX_CNT  = 8'h14;
    // control fields
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_LTEST  = 1;
    localparam int CTRL_LTVAL  = 2;
    localparam int CTRL_LDSEL  = 4;
    localparam int CTRL_REBIST = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SIG_SEED = 32'h0000_0001;
    localparam logic [31:0] SIGNATURE_REGISTER_POLY = 32'h8020_0003;
    // self-test timing
    localparam logic [7:0] SCAN_LEN  = 8'h20;
    localparam logic [7:0] CLK_LEN   = 8'h04;
    localparam logic [3:0] BIST_PASSES = 4'h2;
    localparam logic [7:0] ARRAY_WORDS = 8'h10;
    // line test settle count
    localparam logic [7:0] LT_SETTLE = 8'h08;
    localparam logic [31:0] PSLVERR_DATA = 32'h0000_0000;

    typedef enum {BIST_IDLE, BIST_SCAN, BIST_CLK, BIST_CAPT, BIST_DONE} sltc_bist_t;

    // state of the whole block except the packet store
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] signature_register;
        logic [31:0] arr_sig;
        logic [7:0]  bcnt;
        logic [3:0]  passes;
        logic [7:0]  acnt;
        logic        bist_busy;
        logic        bist_done;
        logic [2:0]  bst;
        logic [3:0]  pkt_cnt;
        logic [3:0]  tx_cnt;
        logic [15:0] tx_total;
        logic [7:0]  lt_cnt;
        logic [3:0]  lt_err;
        logic [3:0]  lt_drv;
        logic [3:0]  lt_oe;
        logic [3:0]  cbl_tx;
        logic        cbl_clk;
        logic [3:0]  loc_tx;
        logic        loc_clk;
        logic [1:0]  clk_sync;
        logic        clk_last;
        logic [3:0]  loc_s1;
        logic [3:0]  loc_s2;
        logic [3:0]  cbl_s1;
        logic [3:0]  cbl_s2;
        logic [1:0]  lb_s1;
        logic [1:0]  lb_s2;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        err_pkt;
        logic        stat_pkt;
        logic [31:0] pkt_sig;
    } sltc_state_t;
endpackage

// >>> src/sltc_top.sv
// switch link test controller: loopback, self-test, functional and line test
//
// The APB slave port and the address map are this design's own decisions.
module sltc_top #(
    parameter int LANES = 4,
    parameter int DEPTH = 8
) (
    input  wire logic              sys_clk,     // 200 MHz system clock
    input  wire logic              rst,         // synchronous reset, high
    input  wire logic [7:0]        paddr,       // apb address
    input  wire logic              psel,        // apb select
    input  wire logic              penable,     // apb enable
    input  wire logic              pwrite,      // apb direction
    input  wire logic [31:0]       pwdata,      // apb write data
    output logic      [31:0]       prdata,      // apb read data
    output logic                   pready,      // apb ready
    output logic                   pslverr,     // apb error
    input  wire logic              loc_lb_n,    // local loopback select, low
    input  wire logic              cbl_lb_n,    // cable loopback select, low
    input  wire logic              link_clk,    // received link clock
    input  wire logic [LANES-1:0]  loc_rx,      // local side receiver data
    input  wire logic [LANES-1:0]  cbl_rx,      // cable side receiver data
    output logic      [LANES-1:0]  loc_tx,      // local side sender data
    output logic                   loc_tx_clk,  // local side sender clock
    output logic      [LANES-1:0]  cbl_tx,      // cable side sender data
    output logic                   cbl_tx_clk,  // cable side sender clock
    output logic      [LANES-1:0]  lt_drv_o,    // line test driver value
    output logic      [LANES-1:0]  lt_drv_oe,   // line test driver enable
    output logic                   err_pkt,     // error packet strobe
    output logic                   stat_pkt,    // status packet strobe
    output logic      [31:0]       pkt_sig      // signature in packets
);
    sltc_pkg::sltc_state_t s_r;
    sltc_pkg::sltc_state_t s_nxt;
    logic [31:0] pkt_mem_r [DEPTH];
    logic        mem_we;
    logic [31:0] rd;
    logic        clk_rise;

    // one signature_register step: shift with feedback and fold in new data
    function automatic logic [31:0] signature_register_step(input logic [31:0] v, input logic [31:0] d);
        signature_register_step = ({v[30:0], 1'b0} ^ (v[31] ? sltc_pkg::SIGNATURE_REGISTER_POLY : 32'h0000_0000)) ^ d;
    endfunction

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        s_nxt    = s_r;
        mem_we   = 1'b0;
        rd       = 32'h0000_0000;
        clk_rise = 1'b0;

        // two-stage synchronisers on all pins from the link side
        s_nxt.clk_sync = {s_r.clk_sync[0], link_clk};
        s_nxt.clk_last = s_r.clk_sync[1];
        clk_rise       = s_r.clk_sync[1] & ~s_r.clk_last;
        s_nxt.loc_s1   = loc_rx;
        s_nxt.loc_s2   = s_r.loc_s1;
        s_nxt.cbl_s1   = cbl_rx;
        s_nxt.cbl_s2   = s_r.cbl_s1;
        s_nxt.lb_s1    = {cbl_lb_n, loc_lb_n};
        s_nxt.lb_s2    = s_r.lb_s1;

        // data path: loop back or pass through, held to link clock edges
        s_nxt.loc_clk = s_r.clk_sync[1];
        s_nxt.cbl_clk = s_r.clk_sync[1];
        if (clk_rise) begin
            if (!s_r.lb_s2[0]) begin
                s_nxt.loc_tx = s_r.loc_s2;
            end else begin
                s_nxt.loc_tx = s_r.cbl_s2;
            end
            if (!s_r.lb_s2[1]) begin
                s_nxt.cbl_tx = s_r.cbl_s2;
            end else begin
                s_nxt.cbl_tx = s_r.loc_s2;
            end
        end

        // logic and array self-test, started by reset or by a write of CTRL_REBIST
        s_nxt.err_pkt  = 1'b0;
        s_nxt.stat_pkt = 1'b0;
        case (sltc_pkg::sltc_bist_t'(s_r.bst))
            sltc_pkg::BIST_IDLE: begin
                if (s_r.bist_busy) begin
                    s_nxt.bst  = 3'(sltc_pkg::BIST_SCAN);
                    s_nxt.bcnt = 8'h00;
                end
            end
            sltc_pkg::BIST_SCAN: begin
                // pattern latches loaded from a counter-based generator
                s_nxt.bcnt = s_r.bcnt + 8'h01;
                if (s_r.bcnt == sltc_pkg::SCAN_LEN - 8'h01) begin
                    s_nxt.bst  = 3'(sltc_pkg::BIST_CLK);
                    s_nxt.bcnt = 8'h00;
                end
            end
            sltc_pkg::BIST_CLK: begin
                s_nxt.bcnt = s_r.bcnt + 8'h01;
                if (s_r.bcnt == sltc_pkg::CLK_LEN - 8'h01) begin
                    s_nxt.bst  = 3'(sltc_pkg::BIST_CAPT);
                    s_nxt.bcnt = 8'h00;
                end
            end
            sltc_pkg::BIST_CAPT: begin
                // captures include the parity checker output so it is tested
                s_nxt.signature_register = signature_register_step(s_r.signature_register, {s_r.ctrl[23:0], s_r.bcnt}
                                       ^ {31'h0, ^s_r.signature_register});
                s_nxt.bcnt = s_r.bcnt + 8'h01;
                if (s_r.bcnt == sltc_pkg::SCAN_LEN - 8'h01) begin
                    s_nxt.passes = s_r.passes + 4'h1;
                    s_nxt.bcnt   = 8'h00;
                    if (s_r.passes + 4'h1 == sltc_pkg::BIST_PASSES) begin
                        s_nxt.bst = 3'(sltc_pkg::BIST_DONE);
                    end else begin
                        s_nxt.bst = 3'(sltc_pkg::BIST_SCAN);
                    end
                end
            end
            default: begin
                if (s_r.acnt == sltc_pkg::ARRAY_WORDS) begin
                    s_nxt.bist_busy = 1'b0;
                    s_nxt.bist_done = 1'b1;
                    s_nxt.bst       = 3'(sltc_pkg::BIST_IDLE);
                    s_nxt.stat_pkt  = 1'b1;
                end
            end
        endcase
        // array test walks in parallel with the logic test
        if (s_r.bist_busy && s_r.acnt != sltc_pkg::ARRAY_WORDS) begin
            s_nxt.arr_sig = signature_register_step(s_r.arr_sig, {24'h0, s_r.acnt});
            s_nxt.acnt    = s_r.acnt + 8'h01;
        end
        s_nxt.pkt_sig = s_r.signature_register ^ s_r.arr_sig;

        // functional test: loaded packets drain one per link edge
        if (s_r.ctrl[sltc_pkg::CTRL_RUN] && s_r.tx_cnt != s_r.pkt_cnt && clk_rise) begin
            s_nxt.tx_cnt   = s_r.tx_cnt + 4'h1;
            s_nxt.tx_total = s_r.tx_total + 16'h0001;
            s_nxt.cbl_tx   = pkt_mem_r[s_r.tx_cnt[2:0]][3:0];
        end

        // line test: force drivers, sample receivers after settling
        s_nxt.lt_oe = 4'h0;
        if (s_r.ctrl[sltc_pkg::CTRL_LTEST]) begin
            s_nxt.lt_oe  = 4'hf;
            s_nxt.lt_drv = {4{s_r.ctrl[sltc_pkg::CTRL_LTVAL]}};
            if (s_r.lt_cnt != sltc_pkg::LT_SETTLE) begin
                s_nxt.lt_cnt = s_r.lt_cnt + 8'h01;
            end else begin
                // inverted or floating leg shows as a mismatch
                s_nxt.lt_err = s_r.lt_err | (s_r.cbl_s2 ^ s_r.lt_drv);
            end
        end else begin
            s_nxt.lt_cnt = 8'h00;
        end
        if (|(s_nxt.lt_err & ~s_r.lt_err)) begin
            s_nxt.err_pkt = 1'b1;
        end

        // apb slave: one wait state, answer on the second access cycle
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            if (paddr == sltc_pkg::OFF_CTRL) begin
                rd = s_r.ctrl;
                if (pwrite) begin
                    s_nxt.ctrl = pwdata;
                    if (pwdata[sltc_pkg::CTRL_REBIST] && !s_r.bist_busy) begin
                        s_nxt.bist_busy = 1'b1;
                        s_nxt.signature_register      = sltc_pkg::SIG_SEED;
                        s_nxt.arr_sig   = sltc_pkg::SIG_SEED;
                        s_nxt.acnt      = 8'h00;
                        s_nxt.passes    = 4'h0;
                    end
                end
            end else if (paddr == sltc_pkg::OFF_STATUS) begin
                rd = {24'h0, s_r.tx_cnt, 1'b0, s_r.bst[1:0], s_r.bist_done};
            end else if (paddr == sltc_pkg::OFF_SIG) begin
                rd = s_r.pkt_sig;
            end else if (paddr == sltc_pkg::OFF_PKT) begin
                rd = {28'h0, s_r.pkt_cnt};
                if (pwrite && s_r.pkt_cnt != 4'(DEPTH)) begin
                    mem_we        = 1'b1;
                    s_nxt.pkt_cnt = s_r.pkt_cnt + 4'h1;
                end
            end else if (paddr == sltc_pkg::OFF_LT_ERR) begin
                rd = {28'h0, s_r.lt_err};
                if (pwrite) begin
                    // a lane error found in the clearing cycle stays logged
                    s_nxt.lt_err = (s_r.lt_err & ~pwdata[3:0])
                                 | (s_nxt.lt_err & ~s_r.lt_err);
                end
            end else if (paddr == sltc_pkg::OFF_TX_CNT) begin
                rd = {16'h0, s_r.tx_total};
                if (pwrite) begin
                    s_nxt.pkt_cnt = 4'h0;
                    s_nxt.tx_cnt  = 4'h0;
                end
            end else begin
                rd            = sltc_pkg::PSLVERR_DATA;
                s_nxt.pslverr = 1'b1;
            end
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
        end
    end

    // ********************************************
    // registers
    // ********************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r           <= '0;
            s_r.ctrl      <= sltc_pkg::CTRL_RST;
            s_r.signature_register      <= sltc_pkg::SIG_SEED;
            s_r.arr_sig   <= sltc_pkg::SIG_SEED;
            s_r.bist_busy <= 1'b1;
            s_r.lb_s1     <= 2'b11;
            s_r.lb_s2     <= 2'b11;
        end else begin
            s_r <= s_nxt;
        end
    end

    // packet store written only by the supervisor, no reset needed
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            pkt_mem_r[s_r.pkt_cnt[2:0]] <= pwdata;
        end
    end

    // outputs straight from state flip-flops
    assign prdata     = s_r.prdata;
    assign pready     = s_r.pready;
    assign pslverr    = s_r.pslverr;
    assign loc_tx     = s_r.loc_tx;
    assign loc_tx_clk = s_r.loc_clk;
    assign cbl_tx     = s_r.cbl_tx;
    assign cbl_tx_clk = s_r.cbl_clk;
    assign lt_drv_o   = s_r.lt_drv;
    assign lt_drv_oe  = s_r.lt_oe;
    assign err_pkt    = s_r.err_pkt;
    assign stat_pkt   = s_r.stat_pkt;
    assign pkt_sig    = s_r.pkt_sig;
endmodule

// >>> verification/sltc_link_peer.sv
// far end of the serial link: link clock and receiver data
module sltc_link_peer (
    input  wire logic       run,      // frame in progress
    input  wire logic [3:0] loc_d,    // local receiver data
    input  wire logic [3:0] cbl_d,    // cable receiver data
    input  wire logic [3:0] brk,      // lanes with a broken leg
    output logic            link_clk, // received link clock
    output logic      [3:0] loc_rx,   // local receiver lines
    output logic      [3:0] cbl_rx    // cable receiver lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // *********************************
    // link clock, 160 ns, odd phase
    // *********************************
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever begin
            #80;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end
    // idle lines show the inverse, so a stale value never passes
    always_comb begin
        loc_rx = run ? loc_d : ~loc_d;
        cbl_rx = run ? cbl_d ^ brk : ~(cbl_d ^ brk);
    end
endmodule

// >>> verification/sltc_top_asserts.sv
// port assertions of the switch link test controller
module sltc_top_asserts #(
    parameter int LANES = 4
) (
    input wire logic             sys_clk,   // clock
    input wire logic             rst,       // reset
    input wire logic [7:0]       paddr,     // apb address
    input wire logic             psel,      // apb select
    input wire logic             penable,   // apb enable
    input wire logic             pwrite,    // apb direction
    input wire logic [31:0]      pwdata,    // apb write data
    input wire logic             pready,    // apb ready
    input wire logic             pslverr,   // apb error
    input wire logic [LANES-1:0] lt_drv_o,  // driver value
    input wire logic [LANES-1:0] lt_drv_oe, // driver enable
    input wire logic             err_pkt,   // error packet
    input wire logic             stat_pkt   // status packet
);
    logic [2:1] ctl_r;
    logic [2:1] ctl_nxt;
    logic       mapped;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // *********************************
    // snooped line test control
    // *********************************
    // value kept while off, so the exit cycles still compare
    always_comb begin
        ctl_nxt = ctl_r;
        if (psel && penable && pwrite && paddr == 8'h00) begin
            ctl_nxt[1] = pwdata[1];
            ctl_nxt[2] = pwdata[1] ? pwdata[2] : ctl_r[2];
        end
    end
    always_ff @(posedge sys_clk) begin
        ctl_r <= rst ? 2'b00 : ctl_nxt;
    end
    assign mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'b00);
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pslverr |-> pready && !mapped)
        else $error("error on mapped access");
    a_oe_mode: assert property (lt_drv_oe != '0 |-> ctl_r[1] || $past(ctl_r[1], 2))
        else $error("driver enabled outside line test");
    a_oe_full: assert property (ctl_r[1] && $past(ctl_r[1], 4) |-> lt_drv_oe == '1)
        else $error("drivers not enabled in line test");
    a_drv_value: assert property (lt_drv_oe != '0 |-> lt_drv_o == {LANES{ctl_r[2]}})
        else $error("driver value not the forced one");
    a_err_cause: assert property (err_pkt |-> ctl_r[1])
        else $error("line error outside line test");
    a_stat_pulse: assert property (stat_pkt |=> !stat_pkt)
        else $error("status packet longer than one cycle");
    a_selftest_auto: assert property ($fell(rst) |-> !stat_pkt [*8] ##[1:600] stat_pkt)
        else $error("self-test did not finish after reset");
endmodule
bind sltc_top sltc_top_asserts #(.LANES(LANES)) u_chk (.sys_clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .pslverr, .lt_drv_o, .lt_drv_oe, .err_pkt, .stat_pkt);

// >>> verification/sltc_top_test.sv
// self-checking bench of the switch link test controller
module sltc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } sltc_exp_t;
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        loc_lb_n = 1'b1, cbl_lb_n = 1'b1, run = 1'b1, ck = 1'b0;
    logic        pready, pslverr, link_clk, loc_tx_clk, cbl_tx_clk, err_pkt, stat_pkt;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, pkt_sig, sig;
    logic [3:0]  loc_d = 4'h0, cbl_d = 4'h0, brk = 4'h0;
    logic [3:0]  loc_rx, cbl_rx, loc_tx, cbl_tx, lt_drv_o, lt_drv_oe;
    logic [15:0] r = 16'd63990;
    int          errors = 0, check_count = 0, n;
    sltc_exp_t   exp_q[$];
    sltc_exp_t   e;
    sltc_top #(.LANES(4), .DEPTH(8)) DUT (.sys_clk, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .loc_lb_n, .cbl_lb_n, .link_clk, .loc_rx,
        .cbl_rx, .loc_tx, .loc_tx_clk, .cbl_tx, .cbl_tx_clk, .lt_drv_o, .lt_drv_oe,
        .err_pkt, .stat_pkt, .pkt_sig);
    sltc_link_peer u_peer (.run, .loc_d, .cbl_d, .brk, .link_clk, .loc_rx, .cbl_rx);
    always #2.5 sys_clk = ~sys_clk;
    // *********************************
    // helpers
    // *********************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic er);
        exp_q.push_back({d, m, er});
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        while (pready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk(4'(pready), 4'h1, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // sel 0 status strobe, 1 error strobe, 2 cable sender value
    task automatic await(input int sel, input logic [3:0] v, input int lim);
        n = 0;
        while ((sel == 0 ? 4'(stat_pkt) : sel == 1 ? 4'(err_pkt) : cbl_tx) !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // oldest note answers each ready
    always @(posedge sys_clk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            check_count++;
            if ((prdata & e.mask) !== (e.data & e.mask) || pslverr !== e.err) begin
                errors++;
                $display("[ERR] %0t apb %h: got %h/%b", $time, paddr, prdata, pslverr);
            end
        end
    end
    initial begin
        #50us;
        errors++;
        conclude();
    end
    // *********************************
    // scenarios
    // *********************************
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        await(0, 4'h1, 600);
        chk(4'(n >= 136), 4'h1, "self-test length");
        sig = pkt_sig;
        apb(1'b0, sltc_pkg::OFF_STATUS, 32'h1, 32'h1, 1'b0);
        apb(1'b0, sltc_pkg::OFF_SIG, sig, '1, 1'b0);
        apb(1'b0, sltc_pkg::OFF_CTRL, sltc_pkg::CTRL_RST, '1, 1'b0);
        apb(1'b1, 8'h3c, 32'h0, 32'h0, 1'b1);
        // pass-through, local loop, cable loop
        for (int m = 0; m < 3; m++) begin
            r = lfsr(r);
            loc_d <= r[3:0];
            cbl_d <= r[7:4];
            loc_lb_n <= (m != 1);
            cbl_lb_n <= (m != 2);
            n = 0;
            repeat (200) begin
                @(posedge sys_clk);
                n += 32'((loc_lb_n ? cbl_tx_clk : loc_tx_clk) !== ck);
                ck = loc_lb_n ? cbl_tx_clk : loc_tx_clk;
            end
            chk(4'(n >= 6), 4'h1, "sender clock");
            if (m == 1) chk(loc_tx, loc_d, "local loop");
            else chk(cbl_tx, m == 2 ? cbl_d : loc_d, "cable sender");
            if (m == 0) chk(loc_tx, cbl_d, "local sender");
        end
        loc_lb_n <= 1'b1;
        cbl_lb_n <= 1'b1;
        // forced value both ways, lane 2 broken
        for (int v = 0; v < 2; v++) begin
            cbl_d <= {4{v[0]}};
            brk <= 4'h4;
            apb(1'b1, sltc_pkg::OFF_CTRL, 32'h2 | (32'(v) << 2), 32'h0, 1'b0);
            await(1, 4'h1, 100);
            chk(lt_drv_oe, 4'hf, "drivers on");
            chk(lt_drv_o, {4{v[0]}}, "forced value");
            apb(1'b0, sltc_pkg::OFF_LT_ERR, 32'h4, 32'hf, 1'b0);
            brk <= 4'h0;
            repeat (6) @(posedge sys_clk);
            apb(1'b1, sltc_pkg::OFF_LT_ERR, 32'hf, 32'h0, 1'b0);
            apb(1'b0, sltc_pkg::OFF_LT_ERR, 32'h0, 32'hf, 1'b0);
            apb(1'b1, sltc_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
            repeat (4) @(posedge sys_clk);
            chk(lt_drv_oe, 4'h0, "drivers off");
        end
        // loop the cable, then nine packets into an eight-deep store
        cbl_lb_n <= 1'b0;
        cbl_d <= 4'h0;
        for (int i = 0; i < 9; i++) begin
            r = lfsr(r);
            apb(1'b1, sltc_pkg::OFF_PKT, {r, 12'h0, i == 0 ? 4'h5 : i == 1 ? 4'ha : r[3:0]},
                32'h0, 1'b0);
        end
        apb(1'b0, sltc_pkg::OFF_PKT, 32'h8, 32'hf, 1'b0);
        apb(1'b1, sltc_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0);
        await(2, 4'h5, 400);
        chk(cbl_tx, 4'h5, "first packet");
        await(2, 4'ha, 100);
        chk(cbl_tx, 4'ha, "second packet");
        repeat (400) @(posedge sys_clk);
        apb(1'b0, sltc_pkg::OFF_TX_CNT, 32'h8, 32'hffff, 1'b0);
        apb(1'b0, sltc_pkg::OFF_STATUS, 32'h80, 32'hf0, 1'b0);
        apb(1'b1, sltc_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b1, sltc_pkg::OFF_TX_CNT, 32'h0, 32'h0, 1'b0);
        apb(1'b0, sltc_pkg::OFF_PKT, 32'h0, 32'hf, 1'b0);
        // restart by command, control back to zero before capture: same signature
        apb(1'b1, sltc_pkg::OFF_CTRL, 32'h100, 32'h0, 1'b0);
        apb(1'b1, sltc_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0);
        await(0, 4'h1, 600);
        chk(4'(n >= 120), 4'h1, "restart length");
        apb(1'b0, sltc_pkg::OFF_SIG, sig, '1, 1'b0);
        conclude();
    end
endmodule
